/* File: rtl/pcs_status_reg.sv */
// configuration command and status registers with sticky error flags
// Functional notes
// - bit 15 sets on address or data parity error detected.
// - bit 14 sets when system error enabled and actually signaled.
// - bit 13 sets when own master cycle ends in master abort.
// - bit 12 sets when own master cycle gets target abort.
// - bit 11 sets when device as target signals target abort.
// - bits 10:9 read 01b; medium device-select timing claimed.
// - bit 8 sets on perr seen, device master, command bit 6 set.
// - bits 7 and 6 read constant zero.
// - bit 5 reads constant one, 66 MHz capable.
// - bit 4 reads one, capabilities list present.
// - bit 3 tracks internal interrupt; intx only if bit3 and not disabled.
// - interrupt disable does not alter the pending bit.
// - bits 2:0 read zero, writes ignored.
// - command bit 10 is dropped by the write mask, so it never blocks the interrupt output.
// - command bit 6 enables driving parity error signal.
// - command bit 8 enables system error driver.
`timescale 1ns/1ps
module pcs_status_reg
  import pcs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire pcs_pkg::pcs_cfg_req_t i_cfg,
  input wire pcs_pkg::pcs_events_t i_events,
  output logic [15:0] o_rdata,
  output logic o_intx_n,
  output logic o_perr_drive_en,
  output logic o_serr_drive_en,
  output logic [1:0] o_select_timing_code
);
  import pcs_pkg::*;

  logic [15:0] command;
  logic detected_parity_error;
  logic signaled_system_error;
  logic received_master_abort_flag;
  logic received_target_abort_flag;
  logic signaled_target_abort_flag;
  logic master_data_parity_flag;
  logic int_pending;

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire status_hit = i_cfg.addr == STATUS_OFFSET;
  wire command_hit = i_cfg.addr == COMMAND_OFFSET;
  wire status_wr = i_cfg.wr && status_hit;
  wire command_wr = i_cfg.wr && command_hit;
  wire [15:0] clr = status_wr ? (i_cfg.wdata & STATUS_W1C_MASK) : 16'h0000;
  wire system_error_enable = command[CMD_SERR_EN];
  wire parity_response_enable = command[CMD_PARITY_RESPONSE_ENABLE];

  wire set_par = i_events.addr_parity_error |
    i_events.data_parity_error;
  // only counts an error that really left the pin
  wire set_serr = system_error_enable &
    i_events.system_error_raised;
  wire set_mabt = i_events.master_abort;
  wire set_tabr = i_events.target_abort_received;
  wire set_tabs = i_events.target_abort_signaled;
  wire set_mdp = i_events.perr_seen & i_events.was_master &
    parity_response_enable;

  // set terms or-ed last so an event beats a clear in the same cycle
  wire next_par = (detected_parity_error & ~clr[BIT_PARITY]) | set_par;
  wire next_serr = (signaled_system_error & ~clr[BIT_SYSERR]) |
    set_serr;
  wire next_mabt = (received_master_abort_flag & ~clr[BIT_RECEIVED_MASTER_ABORT_FLAG]) |
    set_mabt;
  wire next_tabr = (received_target_abort_flag & ~clr[BIT_TABORT_RCV]) |
    set_tabr;
  wire next_tabs = (signaled_target_abort_flag & ~clr[BIT_SIGNALED_TARGET_ABORT_FLAG]) |
    set_tabs;
  wire next_mdp = (master_data_parity_flag & ~clr[BIT_MDPAR]) |
    set_mdp;

  wire [15:0] next_command = command_wr ?
    (i_cfg.wdata & COMMAND_WR_MASK) : command;

  // fixed fields: timing 01b, 66 MHz one, cap list one, 7:6 and 2:0 zero
  wire [15:0] status_value = STATUS_FIXED |
    {detected_parity_error, signaled_system_error,
     received_master_abort_flag, received_target_abort_flag,
     signaled_target_abort_flag, 2'h0, master_data_parity_flag,
     4'h0, int_pending, 3'h0};

  wire [15:0] next_rdata = !i_cfg.rd ? 16'h0000 :
    status_hit ? status_value :
    command_hit ? command : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // state
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      command <= COMMAND_RESET;
      detected_parity_error <= STATUS_RESET[BIT_PARITY];
      signaled_system_error <= STATUS_RESET[BIT_SYSERR];
      received_master_abort_flag <= STATUS_RESET[BIT_RECEIVED_MASTER_ABORT_FLAG];
      received_target_abort_flag <= STATUS_RESET[BIT_TABORT_RCV];
      signaled_target_abort_flag <= STATUS_RESET[BIT_SIGNALED_TARGET_ABORT_FLAG];
      master_data_parity_flag <= STATUS_RESET[BIT_MDPAR];
      int_pending <= STATUS_RESET[BIT_INT_PEND];
    end else begin
      command <= next_command;
      detected_parity_error <= next_par;
      signaled_system_error <= next_serr;
      received_master_abort_flag <= next_mabt;
      received_target_abort_flag <= next_tabr;
      signaled_target_abort_flag <= next_tabs;
      master_data_parity_flag <= next_mdp;
      // disable bit deliberately not in this path
      int_pending <= i_events.internal_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
      o_intx_n <= 1'b1;
      o_perr_drive_en <= 1'b0;
      o_serr_drive_en <= 1'b0;
      o_select_timing_code <= SELECT_TIMING_MEDIUM;
    end else begin
      o_rdata <= next_rdata;
      o_intx_n <= ~(i_events.internal_irq &
        ~next_command[CMD_INT_DIS]);
      o_perr_drive_en <= next_command[CMD_PARITY_RESPONSE_ENABLE];
      o_serr_drive_en <= next_command[CMD_SERR_EN];
      o_select_timing_code <= SELECT_TIMING_MEDIUM;
    end
  end
endmodule

/* File: include/pcs_pkg.sv */
// package for the configuration status register block
package pcs_pkg;
  localparam logic [7:0] STATUS_OFFSET = 8'h06;
  localparam logic [7:0] COMMAND_OFFSET = 8'h04;
  localparam logic [15:0] STATUS_RESET = 16'h0230;
  localparam logic [15:0] COMMAND_RESET = 16'h0000;
  localparam int BIT_PARITY = 15;
  localparam int BIT_SYSERR = 14;
  localparam int BIT_RECEIVED_MASTER_ABORT_FLAG = 13;
  localparam int BIT_TABORT_RCV = 12;
  localparam int BIT_SIGNALED_TARGET_ABORT_FLAG = 11;
  localparam int BIT_TIMING_HI = 10;
  localparam int BIT_TIMING_LO = 9;
  localparam int BIT_MDPAR = 8;
  localparam int BIT_INT_PEND = 3;
  localparam int CMD_INT_DIS = 10;
  localparam int CMD_SERR_EN = 8;
  localparam int CMD_PARITY_RESPONSE_ENABLE = 6;
  localparam logic [1:0] SELECT_TIMING_MEDIUM = 2'h1;
  localparam logic [15:0] STATUS_W1C_MASK = 16'hf900;
  localparam logic [15:0] COMMAND_WR_MASK = 16'h0156;
  localparam logic [15:0] STATUS_FIXED = 16'h0230;

  typedef struct packed {
    logic addr_parity_error;
    logic data_parity_error;
    logic system_error_raised;
    logic master_abort;
    logic target_abort_received;
    logic target_abort_signaled;
    logic perr_seen;
    logic was_master;
    logic internal_irq;
  } pcs_events_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } pcs_cfg_req_t;
endpackage

/* File: testbench/pcs_bus_agent.sv */
// bus agent model raising event pulses
`timescale 1ns/1ps
module pcs_bus_agent (
  input wire logic i_core_clk,
  output pcs_pkg::pcs_events_t o_events
);
  logic [8:0] pulse = '0;
  logic irq = 1'b0;
  assign o_events = pulse | {8'h00, irq};
  task automatic fire(input logic [8:0] e);
    @(posedge i_core_clk) #1 pulse = e;
    @(posedge i_core_clk) #1 pulse = '0;
  endtask
endmodule

/* File: testbench/pcs_status_reg_sva.sv */
// assertions on the status register ports
`timescale 1ns/1ps
module pcs_status_reg_sva (
  input wire logic i_core_clk, i_reset, o_intx_n, o_perr_drive_en,
  input wire logic o_serr_drive_en, input wire logic [15:0] o_rdata,
  input wire logic [1:0] o_select_timing_code,
  input wire pcs_pkg::pcs_cfg_req_t i_cfg,
  input wire pcs_pkg::pcs_events_t i_events
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  wire rs = i_cfg.rd && i_cfg.addr == 8'h06;
  property p_tc; o_select_timing_code == 2'h1; endproperty
  a_tc: assert property (p_tc) else $error("tc");
  property p_hw0; rs |=> o_rdata[7:6] == 2'h0; endproperty
  a_hw0: assert property (p_hw0) else $error("hw0");
  property p_cap; rs |=> o_rdata[5:4] == 2'h3; endproperty
  a_cap: assert property (p_cap) else $error("cap");
  property p_rsv; rs |=> o_rdata[2:0] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("rsv");
  property p_par; i_events.addr_parity_error ##1 !i_cfg.wr ##1 rs
    |=> o_rdata[15]; endproperty
  a_par: assert property (p_par) else $error("par");
  property p_irq; i_events.internal_irq |=> !o_intx_n; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_nirq; !i_events.internal_irq |=> o_intx_n; endproperty
  a_nirq: assert property (p_nirq) else $error("nirq");
  property p_perr; $changed(o_perr_drive_en) |-> $past(i_cfg.wr) ||
    $past(i_cfg.wr, 2); endproperty
  a_perr: assert property (p_perr) else $error("perr");
endmodule
bind pcs_status_reg pcs_status_reg_sva pcs_status_reg_sva_i (.*);

/* File: testbench/pcs_status_reg_test.sv */
// self-checking bench for the status register
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module pcs_status_reg_test;
  import pcs_pkg::*;
  logic i_core_clk = 1'b0, i_reset = 1'b1, o_intx_n;
  logic o_perr_drive_en, o_serr_drive_en;
  logic [1:0] o_select_timing_code;
  logic [15:0] o_rdata;
  pcs_cfg_req_t i_cfg = '0;
  pcs_events_t i_events;
  int err_total = 0, checks = 0, cyc_n = 0;
  logic [24:0] rows [8] = '{{9'h100, 16'h8230}, {9'h080, 16'h8230},
    {9'h040, 16'h4230}, {9'h020, 16'h2230}, {9'h010, 16'h1230},
    {9'h008, 16'h0a30}, {9'h006, 16'h0330}, {9'h004, 16'h0230}};
  always #2 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (++cyc_n == 1000) end_sim(1);
  pcs_bus_agent pcs_bus_agent_i (.i_core_clk(i_core_clk), .o_events(i_events));
  pcs_status_reg pcs_status_reg_i (.*);
  task automatic end_sim(input int bad);
    if (err_total + bad == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // a read compares d against the data answered one cycle later
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge i_core_clk) #1 i_cfg = '{w, !w, a, d};
    @(posedge i_core_clk) #1 i_cfg = '0;
    if (!w) `CHK("rdata", d, o_rdata)
  endtask
  initial begin
    repeat (4) @(posedge i_core_clk);
    #1 i_reset = 1'b0;
    bus(1'b0, 8'h06, STATUS_RESET);
    bus(1'b1, 8'h04, 16'h0540);
    `CHK("serr_en", 1'b1, o_serr_drive_en)
    `CHK("parity_response_enable", 1'b1, o_perr_drive_en)
    `CHK("timing", 2'h1, o_select_timing_code)
    bus(1'b0, 8'h04, 16'h0140);
    foreach (rows[i]) begin
      pcs_bus_agent_i.fire(rows[i][24:16]);
      bus(1'b0, 8'h06, rows[i][15:0]);
      bus(1'b1, 8'h06, 16'hffff);
    end
    pcs_bus_agent_i.irq = 1'b1;
    bus(1'b0, 8'h06, 16'h0238);
    `CHK("intx", 1'b0, o_intx_n)
    pcs_bus_agent_i.irq = 1'b0;
    bus(1'b0, 8'h08, 16'h0000);
    // event and clear on one edge: the event must win
    fork
      pcs_bus_agent_i.fire(9'h100);
      bus(1'b1, 8'h06, 16'hffff);
    join
    bus(1'b0, 8'h06, 16'h8230);
    bus(1'b1, 8'h06, 16'hffff);
    pcs_bus_agent_i.fire(9'h020);
    bus(1'b1, 8'h06, 16'h0000);
    bus(1'b0, 8'h06, 16'h2230);
    pcs_bus_agent_i.fire(9'h010);
    // reset in mid-run drops flags and command
    @(posedge i_core_clk) #1 i_reset = 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1 i_reset = 1'b0;
    `CHK("perr_rst", 1'b0, o_perr_drive_en)
    `CHK("serr_rst", 1'b0, o_serr_drive_en)
    `CHK("intx_rst", 1'b1, o_intx_n)
    bus(1'b0, 8'h06, STATUS_RESET);
    // system error with the driver disabled leaves bit 14 clear
    pcs_bus_agent_i.fire(9'h040);
    bus(1'b0, 8'h06, 16'h0230);
    pcs_bus_agent_i.fire(9'h006);
    bus(1'b0, 8'h06, 16'h0230);
    end_sim(0);
  end
endmodule
